// ===== lcd_multiplex_scan_control_tb.sv
// lcd_multiplex_scan_control_tb: registers, memory, ports and scan checks
// assumes checker and panel model are compiled first
`timescale 1ns/1ps
module lcd_multiplex_scan_control_tb;
   logic mclk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, watch_tick = 0;
   logic scan_clock_en = 1, cpu_req = 0, cpu_we = 0, cpu_bit_op = 0, clr = 1, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0] pstrb = 4'hf, cpu_wdata = 4'h0, cpu_rdata, lit, nib;
   logic [8:0] cpu_addr = 9'h1ec;
   logic [1:0] cpu_bit = 2'h0;
   logic [7:0] common_lines, upper_segment_port_lines, port_line_mode;
   logic [39:0] segment_lines;
   logic pready, pslverr, cpu_hit, bias_supply_out, bias_supply_oe, low_voltage_drive_sel;
   logic panel_scan_clock, frame_sync, hit, sc_last = 0, fs_last = 0;
   logic [3:0] wired_now = 4'hf;
   logic [3:0] wired [6] = '{4'hf, 4'hf, 4'h3, 4'h7, 4'h7, 4'hf};
   // scan clock toggle period in mclk cycles: two cycles per watch tick
   int gap [6] = '{128, 256, 128, 128, 128, 128};
   int sc_toggles = 0, fs_rises = 0, sc_gap = 0, sc_period = 0;
   logic [7:0] modes [6] = '{8'h3c, 8'h2c, 8'h3a, 8'h39, 8'h3b, 8'h38};
   logic [3:0] mem [6] = '{4'he, 4'hf, 4'hd, 4'hb, 4'h7, 4'h5};
   logic [3:0] expect_lit [6] = '{4'h0, 4'hf, 4'h1, 4'h3, 4'h7, 4'h5};
   int failures = 0, compares = 0, cycles = 0;
   lcdmsc_top DUT (.mclk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
      .pready, .pslverr, .cpu_req, .cpu_we, .cpu_bit_op, .cpu_addr, .cpu_bit, .cpu_wdata,
      .cpu_rdata, .cpu_hit, .watch_tick, .scan_clock_en, .common_lines, .segment_lines,
      .upper_segment_port_lines, .port_line_mode, .bias_supply_out, .bias_supply_oe,
      .low_voltage_drive_sel, .panel_scan_clock, .frame_sync);
   lcdmsc_panel panel (.mclk, .clear(clr), .common_lines, .wired(wired_now),
      .seg_code(segment_lines[1:0]), .lit);
   // clock, watch tick every second cycle, run limit
   initial forever #12.5 mclk = ~mclk;
   always @(posedge mclk) begin
      watch_tick <= ~watch_tick;
      cycles++;
      if (cycles == 20000) begin
         failures++;
         end_sim();
      end
   end
   // scan clock period and sync activity, counts cleared while clr is high
   always @(posedge mclk) begin
      sc_last <= panel_scan_clock;
      fs_last <= frame_sync;
      if (panel_scan_clock != sc_last) begin
         sc_period <= sc_gap + 1;
         sc_gap <= 0;
      end else begin
         sc_gap <= sc_gap + 1;
      end
      if (clr) begin
         sc_toggles <= 0;
         fs_rises <= 0;
      end else begin
         if (panel_scan_clock != sc_last) begin
            sc_toggles <= sc_toggles + 1;
         end
         if (frame_sync && !fs_last) begin
            fs_rises <= fs_rises + 1;
         end
      end
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // one apb transfer: setup, access until pready, release
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) begin
         @(posedge mclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask
   // one cpu memory access, read nibble kept in nib
   task automatic cpu(input logic we, input logic bop, input logic [8:0] a, input logic [3:0] d);
      cpu_req <= 1'b1;
      cpu_we <= we;
      cpu_bit_op <= bop;
      cpu_addr <= a;
      cpu_wdata <= d;
      @(posedge mclk);
      hit = cpu_hit;
      cpu_req <= 1'b0;
      @(posedge mclk);
      nib = cpu_rdata;
      @(posedge mclk);
   endtask
   task automatic end_sim;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      apb(0, 12'h000, 0);
      check("drive_ctrl", rd, 0);
      apb(0, 12'h004, 0);
      check("mode_sel", rd, 0);
      apb(1, 12'h000, 32'h9);
      // a write without byte lane 0 leaves the nibble alone
      pstrb <= 4'he;
      apb(1, 12'h000, 32'h0);
      pstrb <= 4'hf;
      apb(0, 12'h000, 0);
      check("drive_ctrl", rd, 32'h9);
      repeat (300) @(posedge mclk);
      check("low_volt", low_voltage_drive_sel, 1);
      check("bias_oe", bias_supply_oe, 1);
      check("bias_out", bias_supply_out, 1);
      check("seg_sel", |(segment_lines & {20{2'h2}}), 0);
      check("frame_sync", frame_sync, 0);
      check("scan_clk", panel_scan_clock, 0);
      apb(0, 12'h100, 0);
      check("slverr", err, 1);
      check("unmapped", rd, 0);
      // cpu port and apb see one memory
      apb(1, 12'h040, 32'he);
      cpu(0, 0, 9'h1ec, 0);
      check("cpu_rd", nib, 4'he);
      check("hit", hit, 1);
      cpu(1, 0, 9'h1ff, 4'h6);
      apb(0, 12'h08c, 0);
      check("mem19", rd, 6);
      cpu_bit <= 2'h3;
      cpu(1, 1, 9'h1ff, 4'h1);
      apb(0, 12'h08c, 0);
      check("bit_wr", rd, 32'he);
      cpu(0, 1, 9'h1ff, 0);
      check("bit_rd", nib, 4'h1);
      cpu(0, 0, 9'h1eb, 0);
      check("miss", hit, 0);
      // bit ports with bias off
      for (int i = 0; i < 8; i++) begin
         apb(1, 12'h070 + 12'(4 * i), {24'h0, 8'hb5 >> i});
      end
      apb(1, 12'h000, 0);
      apb(1, 12'h004, 32'hc0);
      repeat (4) @(posedge mclk);
      check("port_lines", upper_segment_port_lines, 8'hb5);
      check("port_mode", port_line_mode, 8'hff);
      check("bias_oe", bias_supply_oe, 0);
      apb(1, 12'h004, 0);
      // scan every division mode with sync on
      apb(1, 12'h000, 32'h5);
      for (int k = 0; k < 6; k++) begin
         apb(1, 12'h040, {28'h0, mem[k]});
         apb(1, 12'h004, {24'h0, modes[k]});
         wired_now <= wired[k];
         repeat (140) @(posedge mclk);
         clr <= 1'b0;
         repeat (1100) @(posedge mclk);
         check("lit", lit, expect_lit[k]);
         check("scan_period", sc_period, gap[k]);
         check("frame_sync", (k < 2) ? frame_sync : (fs_rises != 0), 1);
         clr <= 1'b1;
      end
      // scan clock held while the watch timer clock is off
      scan_clock_en <= 1'b0;
      repeat (4) @(posedge mclk);
      clr <= 1'b0;
      repeat (400) @(posedge mclk);
      check("scan_hold", sc_toggles, 0);
      clr <= 1'b1;
      scan_clock_en <= 1'b1;
      apb(1, 12'h000, 0);
      repeat (3) @(posedge mclk);
      check("commons_off", common_lines, 0);
      check("segs_off", |segment_lines, 0);
      check("supply_off", bias_supply_oe, 0);
      check("sync_off", panel_scan_clock, 0);
      // second reset in mid-run clears both control registers
      apb(1, 12'h000, 32'h9);
      apb(1, 12'h004, 32'h38);
      reset <= 1'b1;
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      apb(0, 12'h000, 0);
      check("drive_rst", rd, 0);
      apb(0, 12'h004, 0);
      check("mode_rst", rd, 0);
      check("low_volt_rst", low_voltage_drive_sel, 0);
      end_sim();
   end
endmodule

// ===== lcdmsc_chk.sv
// lcdmsc_chk: port-level assertions for the scan controller
// assumes it is bound to lcdmsc_top and sees only its ports
`timescale 1ns/1ps
module lcdmsc_chk #(
   parameter int SEGMENTS = 20
) (
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // apb handshake
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   // panel codes and supply
   input wire logic [7:0] common_lines,
   input wire logic [2*SEGMENTS-1:0] segment_lines,
   input wire logic [7:0] port_line_mode,
   input wire logic bias_supply_out,
   input wire logic bias_supply_oe,
   input wire logic low_voltage_drive_sel,
   input wire logic frame_sync
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   logic [3:0] sel;
   // select bits of the four commons
   assign sel = {common_lines[7], common_lines[5], common_lines[3], common_lines[1]};
   reset_clear_a: assert property ($fell(reset) |-> !low_voltage_drive_sel && !bias_supply_oe)
      else $error("outputs not cleared by reset");
   bias_off_a: assert property (!bias_supply_oe |-> common_lines == 8'h00 && segment_lines == '0)
      else $error("panel driven with bias off");
   supply_high_a: assert property (bias_supply_oe |-> bias_supply_out)
      else $error("bias supply not high");
   one_common_a: assert property (bias_supply_oe |-> $onehot0(sel) || sel == 4'hf)
      else $error("several commons selected");
   seg_phase_a: assert property (bias_supply_oe |-> segment_lines[0] != common_lines[0])
      else $error("segment phase equals common phase");
   phase_wrap_a: assert property (bias_supply_oe && $past(bias_supply_oe) && $changed(common_lines[0])
      |-> common_lines[1])
      else $error("phase changed away from frame start");
   port_quiet_a: assert property (port_line_mode[7] |-> segment_lines[2*SEGMENTS-1 -: 2] == 2'h0)
      else $error("port segment carries drive code");
   sync_slot_a: assert property (frame_sync && bias_supply_oe |-> sel[0])
      else $error("frame sync outside first slot");
   slverr_phase_a: assert property (pslverr |-> psel && penable && pready)
      else $error("slave error outside access phase");
endmodule
bind lcdmsc_top lcdmsc_chk #(.SEGMENTS(SEGMENTS)) chk (.mclk(mclk), .reset(reset), .psel(psel),
   .penable(penable), .pready(pready), .pslverr(pslverr), .common_lines(common_lines),
   .segment_lines(segment_lines), .port_line_mode(port_line_mode),
   .bias_supply_out(bias_supply_out), .bias_supply_oe(bias_supply_oe),
   .low_voltage_drive_sel(low_voltage_drive_sel), .frame_sync(frame_sync));

// ===== lcdmsc_panel.sv
// lcdmsc_panel: glass model latching which pixels of segment 0 lit
// assumes {select, phase} codes on commons and on segment 0
`timescale 1ns/1ps
module lcdmsc_panel (
   // clock and clear
   input wire logic mclk,
   input wire logic clear,
   // drive codes
   input wire logic [7:0] common_lines,
   input wire logic [3:0] wired,
   input wire logic [1:0] seg_code,
   // pixels seen lit
   output logic [3:0] lit
);
   // full voltage only with both selected and opposite phases
   always_ff @(posedge mclk) begin
      for (int c = 0; c < 4; c++) begin
         if (clear) begin
            lit[c] <= 1'b0;
         end else if (wired[c] && common_lines[2*c+1] && seg_code[1]
            && common_lines[2*c] != seg_code[0]) begin
            // commons left open on the glass never light a pixel
            lit[c] <= 1'b1;
         end
      end
   end
endmodule

// ===== lcdmsc_pkg.sv
// lcdmsc_pkg: constants for the lcd multiplex scan controller
// assumes an apb slave at 32-bit data, one register per aligned word
package lcdmsc_pkg;
   // byte addresses of the apb registers
   localparam logic [11:0] ADDR_DRIVE_CTRL = 12'h000;
   localparam logic [11:0] ADDR_MODE_SEL = 12'h004;
   localparam logic [11:0] ADDR_STATUS = 12'h008;
   localparam logic [11:0] ADDR_MEM_BASE = 12'h040;
   // display memory window in cpu data space
   localparam int MEM_FIRST = 'h1ec;
   localparam int MEM_LAST = 'h1ff;
   localparam int MEM_WORDS = 20;
   localparam int PORT_FIRST_IDX = 12;
   // drive control field positions
   localparam int DC_BIAS_POWER = 0;
   localparam int DC_SYNC_OUT = 2;
   localparam int DC_LOW_VOLT = 3;
   localparam logic [3:0] DRIVE_CTRL_RESET = 4'h0;
   // mode select fields
   localparam int MS_DISPLAY_ON = 3;
   localparam int MS_CLK_LO = 4;
   localparam int MS_PORT_LO = 6;
   localparam int MS_PORT_HI = 7;
   localparam logic [7:0] MODE_SEL_RESET = 8'h00;
   // time-division encodings of mode bits 2:0
   localparam logic [2:0] DIV4_B3 = 3'h0;
   localparam logic [2:0] DIV3_B3 = 3'h1;
   localparam logic [2:0] DIV2_B2 = 3'h2;
   localparam logic [2:0] DIV3_B2 = 3'h3;
   localparam logic [2:0] DIV_STATIC = 3'h4;
   // watch timer input rate and scan clock divider base
   localparam int WATCH_HZ = 32768;
   localparam int SCAN_DIV_MAX_LOG2 = 9;
   // pin level codes: {select, phase}
   localparam logic [1:0] LVL_NONSEL_POS = 2'h0;
   localparam logic [1:0] LVL_NONSEL_NEG = 2'h1;
   localparam logic [1:0] LVL_SEL_POS = 2'h2;
   localparam logic [1:0] LVL_SEL_NEG = 2'h3;
endpackage

// ===== lcdmsc_scan_div.sv
// lcdmsc_scan_div: divides the watch timer tick into the scan clock tick
// assumes watch_tick is a one-cycle pulse at the watch timer input rate
`timescale 1ns/1ps
module lcdmsc_scan_div (
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // control
   input wire logic enable,
   input wire logic [1:0] rate_sel,
   input wire logic watch_tick,
   // scan tick out
   output logic scan_tick
);
   logic [8:0] count;
   logic [8:0] limit;

   // 64, 128, 256, 512 hz from watch rate over 2^9..2^6
   always_comb begin
      limit = 9'((1 << (lcdmsc_pkg::SCAN_DIV_MAX_LOG2 - int'(rate_sel))) - 1);
   end

   // prescale counter, cleared to zero while the watch timer clock is off
   always_ff @(posedge mclk) begin
      if (reset || !enable) begin
         count <= 9'h000;
         scan_tick <= 1'b0;
      end else begin
         scan_tick <= 1'b0;
         if (watch_tick) begin
            if (count >= limit) begin
               count <= 9'h000;
               scan_tick <= 1'b1;
            end else begin
               count <= count + 9'h001;
            end
         end
      end
   end
endmodule

// ===== lcdmsc_top.sv
// lcdmsc_top: lcd multiplex scan controller with apb registers and
// display memory; assumes analog drivers turn level codes into voltages
//
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
module lcdmsc_top #(
   parameter int SEGMENTS = 20
) (
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // cpu data memory port for 1ech..1ffh
   input wire logic cpu_req,
   input wire logic cpu_we,
   input wire logic cpu_bit_op,
   input wire logic [8:0] cpu_addr,
   input wire logic [1:0] cpu_bit,
   input wire logic [3:0] cpu_wdata,
   output logic [3:0] cpu_rdata,
   output logic cpu_hit,
   // watch timer
   input wire logic watch_tick,
   input wire logic scan_clock_en,
   // panel level codes
   output logic [7:0] common_lines,
   output logic [2*SEGMENTS-1:0] segment_lines,
   output logic [7:0] upper_segment_port_lines,
   output logic [7:0] port_line_mode,
   // bias supply
   output logic bias_supply_out,
   output logic bias_supply_oe,
   output logic low_voltage_drive_sel,
   // expansion sync
   output logic panel_scan_clock,
   output logic frame_sync
);
   logic [3:0] lcd_drive_control;
   logic [7:0] display_mode_select;
   logic [3:0] disp_mem [SEGMENTS];
   logic [1:0] slot;
   logic phase;
   logic scan_tick;
   logic scan_clk_level;
   logic [2:0] div_code;
   logic [1:0] last_slot;
   logic bias_on;
   logic disp_on;
   logic apb_access;
   logic apb_write;
   logic [11:0] mem_off;
   logic mem_apb_hit;
   logic [4:0] mem_apb_idx;
   logic [4:0] cpu_idx;
   logic [3:0] com_sel;
   logic [SEGMENTS-1:0] seg_sel;
   logic [SEGMENTS-1:0] is_port;

   // one-cycle access phase with no wait states
   assign pready = 1'b1;
   assign apb_access = psel && penable;
   assign apb_write = apb_access && pwrite;
   assign mem_off = paddr - lcdmsc_pkg::ADDR_MEM_BASE;
   assign mem_apb_idx = mem_off[6:2];
   assign mem_apb_hit = (paddr >= lcdmsc_pkg::ADDR_MEM_BASE) && (mem_off[1:0] == 2'h0)
      && (mem_off[11:2] < 10'(SEGMENTS));
   assign cpu_idx = 5'(cpu_addr - 9'(lcdmsc_pkg::MEM_FIRST));
   assign cpu_hit = cpu_req && (cpu_addr >= 9'(lcdmsc_pkg::MEM_FIRST))
      && (cpu_addr <= 9'(lcdmsc_pkg::MEM_LAST));
   assign bias_on = lcd_drive_control[lcdmsc_pkg::DC_BIAS_POWER];
   assign disp_on = display_mode_select[lcdmsc_pkg::MS_DISPLAY_ON];
   assign div_code = display_mode_select[2:0];
   assign low_voltage_drive_sel = lcd_drive_control[lcdmsc_pkg::DC_LOW_VOLT];

   // unmapped addresses answer with an error
   always_comb begin
      pslverr = 1'b0;
      if (apb_access) begin
         pslverr = !(paddr == lcdmsc_pkg::ADDR_DRIVE_CTRL || paddr == lcdmsc_pkg::ADDR_MODE_SEL
            || paddr == lcdmsc_pkg::ADDR_STATUS || mem_apb_hit);
      end
   end

   // drive control nibble, written whole through byte lane 0
   always_ff @(posedge mclk) begin
      if (reset) begin
         lcd_drive_control <= lcdmsc_pkg::DRIVE_CTRL_RESET;
      end else if (apb_write && paddr == lcdmsc_pkg::ADDR_DRIVE_CTRL && pstrb[0]) begin
         lcd_drive_control <= pwdata[3:0];
      end
   end

   // mode select byte
   always_ff @(posedge mclk) begin
      if (reset) begin
         display_mode_select <= lcdmsc_pkg::MODE_SEL_RESET;
      end else if (apb_write && paddr == lcdmsc_pkg::ADDR_MODE_SEL && pstrb[0]) begin
         display_mode_select <= pwdata[7:0];
      end
   end

   // display memory: cpu bit or nibble writes, apb nibble writes
   always_ff @(posedge mclk) begin
      if (cpu_hit && cpu_we) begin
         if (cpu_bit_op) begin
            disp_mem[cpu_idx][cpu_bit] <= cpu_wdata[0];
         end else begin
            disp_mem[cpu_idx] <= cpu_wdata;
         end
      end else if (apb_write && mem_apb_hit && pstrb[0]) begin
         disp_mem[mem_apb_idx] <= pwdata[3:0];
      end
   end

   // cpu read data, bit reads return the bit in position 0
   always_ff @(posedge mclk) begin
      if (reset) begin
         cpu_rdata <= 4'h0;
      end else if (cpu_hit && !cpu_we) begin
         cpu_rdata <= cpu_bit_op ? {3'h0, disp_mem[cpu_idx][cpu_bit]} : disp_mem[cpu_idx];
      end
   end

   // apb read mux, registered at the end of the setup cycle
   always_ff @(posedge mclk) begin
      if (reset) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= 32'h0000_0000;
         if (paddr == lcdmsc_pkg::ADDR_DRIVE_CTRL) begin
            prdata <= {28'h0, lcd_drive_control};
         end else if (paddr == lcdmsc_pkg::ADDR_MODE_SEL) begin
            prdata <= {24'h0, display_mode_select};
         end else if (paddr == lcdmsc_pkg::ADDR_STATUS) begin
            prdata <= {28'h0, phase, scan_clock_en, slot};
         end else if (mem_apb_hit) begin
            prdata <= {28'h0, disp_mem[mem_apb_idx]};
         end
      end
   end

   // scan clock tick from the watch timer input
   lcdmsc_scan_div u_div (
      .mclk(mclk),
      .reset(reset),
      .enable(scan_clock_en),
      .rate_sel(display_mode_select[5:lcdmsc_pkg::MS_CLK_LO]),
      .watch_tick(watch_tick),
      .scan_tick(scan_tick)
   );

   // last slot index for the chosen time division
   always_comb begin
      unique case (div_code)
         lcdmsc_pkg::DIV4_B3: last_slot = 2'h3;
         lcdmsc_pkg::DIV3_B3: last_slot = 2'h2;
         lcdmsc_pkg::DIV2_B2: last_slot = 2'h1;
         lcdmsc_pkg::DIV3_B2: last_slot = 2'h2;
         default: last_slot = 2'h0;
      endcase
   end

   // slot counter and frame phase
   always_ff @(posedge mclk) begin
      if (reset) begin
         slot <= 2'h0;
         phase <= 1'b0;
      end else if (scan_tick) begin
         if (slot >= last_slot) begin
            slot <= 2'h0;
            phase <= !phase;
         end else begin
            slot <= slot + 2'h1;
         end
      end
   end

   // scan clock level and frame sync, half rate square
   always_ff @(posedge mclk) begin
      if (reset) begin
         scan_clk_level <= 1'b0;
         panel_scan_clock <= 1'b0;
         frame_sync <= 1'b0;
      end else begin
         if (scan_tick) begin
            scan_clk_level <= !scan_clk_level;
         end
         panel_scan_clock <= lcd_drive_control[lcdmsc_pkg::DC_SYNC_OUT] && scan_clk_level;
         frame_sync <= lcd_drive_control[lcdmsc_pkg::DC_SYNC_OUT] && (slot == 2'h0);
      end
   end

   // common select pattern: static selects all four
   always_comb begin
      if (div_code == lcdmsc_pkg::DIV_STATIC) begin
         com_sel = 4'hf;
      end else begin
         com_sel = 4'(4'h1 << slot);
      end
   end

   // segment select: bit of current slot only, so unused bits stay unread
   always_comb begin
      for (int i = 0; i < SEGMENTS; i++) begin
         seg_sel[i] = disp_on && disp_mem[i][slot];
      end
   end

   // upper segments used as bit ports, four at a time
   always_comb begin
      is_port = '0;
      for (int i = 0; i < 8; i++) begin
         is_port[lcdmsc_pkg::PORT_FIRST_IDX + i] = (i < 4) ?
            display_mode_select[lcdmsc_pkg::MS_PORT_HI] :
            display_mode_select[lcdmsc_pkg::MS_PORT_LO];
      end
   end

   // registered pin codes
   always_ff @(posedge mclk) begin
      if (reset) begin
         common_lines <= 8'h00;
         segment_lines <= '0;
         upper_segment_port_lines <= 8'h00;
         port_line_mode <= 8'h00;
         bias_supply_out <= 1'b0;
         bias_supply_oe <= 1'b0;
      end else begin
         bias_supply_out <= bias_on;
         bias_supply_oe <= bias_on;
         for (int c = 0; c < 4; c++) begin
            common_lines[2*c +: 2] <= bias_on ? {com_sel[c], phase} : 2'h0;
         end
         for (int s = 0; s < SEGMENTS; s++) begin
            // segment phase is inverted so only select/select reaches full level
            segment_lines[2*s +: 2] <= (bias_on && !is_port[s]) ?
               {seg_sel[s], !phase} : 2'h0;
         end
         for (int p = 0; p < 8; p++) begin
            upper_segment_port_lines[p] <= disp_mem[lcdmsc_pkg::PORT_FIRST_IDX + p][0];
            port_line_mode[p] <= is_port[lcdmsc_pkg::PORT_FIRST_IDX + p];
         end
      end
   end
endmodule
